// [core/rde_pkg.sv]
// Shared constants for the ring DMA error handling block
package rde_pkg;
  // Internal error status bit positions
  localparam int IE_OVERRUN = 0;
  localparam int IE_UNDERRUN = 1;
  localparam int IE_TXPAR = 2;
  localparam int IE_MACHS = 3;
  localparam int IE_MEMOVR = 4;
  localparam int IE_PORTB = 5;
  localparam int IE_PORTA = 6;
  localparam int IE_WIDTH = 7;
  localparam logic [6:0] IE_RESET = 7'h00;
  // Port error codes written into indications
  localparam logic [2:0] PERR_NONE = 3'h0;
  localparam logic [2:0] PERR_PAR_DATA = 3'h2;
  localparam logic [2:0] PERR_PAR_ADDR = 3'h6;
  localparam logic [2:0] PERR_PAR_LATE = 3'h7;
  // Indication length in bytes
  localparam int IND_BYTES = 8;
  localparam logic [3:0] IND_BYTES_M1 = 4'h7;
  localparam int NUM_RINGS = 4;
  typedef enum logic [1:0] {
    RDE_RING_STOPPED = 2'b00,
    RDE_RING_READY = 2'b01,
    RDE_RING_EMPTY = 2'b10,
    RDE_RING_FETCH = 2'b11
  } rde_ring_state_t;
endpackage

// [core/rde_sticky_reg.sv]
`timescale 1ns/1ps
// Bank of sticky flags: hardware sets, host clears, set wins
module rde_sticky_reg #(
  parameter int WIDTH = 7
) (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] setVec,
  input wire logic [WIDTH-1:0] clrVec,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // Set beats clear so an event in the clearing cycle survives
  assign flags_nxt = (flags_r & ~clrVec) | setVec;
  assign flags = flags_r;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule // rde_sticky_reg

// [core/rde_ring_ctl.sv]
`timescale 1ns/1ps
// One descriptor ring: state, parity and operation error flags
module rde_ring_ctl (
  input wire logic mclk,
  input wire logic rstN,
  input wire logic ringDefine,
  input wire logic ringReadyAccess,
  input wire logic stopCmd,
  input wire logic fetchStart,
  input wire logic fetchDone,
  input wire logic fetchParityErr,
  input wire logic operationErr,
  output rde_pkg::rde_ring_state_t ringState,
  output logic ringParityFlag,
  output logic ringOperationErrorFlag,
  output logic ringErrEvent,
  output logic fetchAllowed,
  output logic loadDescriptor
);
  rde_pkg::rde_ring_state_t state_r;
  rde_pkg::rde_ring_state_t state_nxt;
  logic par_r;
  logic opErr_r;
  wire inFetch = (state_r == rde_pkg::RDE_RING_FETCH);
  wire fault = inFetch && (fetchParityErr || operationErr);
  wire reArm = ringDefine || ringReadyAccess;

  // Fetch only in the ready state; a ring ready access reaches it even without a define
  assign fetchAllowed = (state_r == rde_pkg::RDE_RING_READY);
  // A faulty descriptor never enters the ring FIFO; pointer stays put
  assign loadDescriptor = inFetch && fetchDone && !fault;
  assign ringErrEvent = fault;
  assign ringState = state_r;
  assign ringParityFlag = par_r;
  assign ringOperationErrorFlag = opErr_r;

  // Ring state sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rde_pkg::RDE_RING_STOPPED: begin
        if (ringReadyAccess) state_nxt = rde_pkg::RDE_RING_READY;
      end
      rde_pkg::RDE_RING_READY: begin
        if (fetchStart) state_nxt = rde_pkg::RDE_RING_FETCH;
      end
      rde_pkg::RDE_RING_FETCH: begin
        if (fault) state_nxt = rde_pkg::RDE_RING_EMPTY;
        else if (fetchDone) state_nxt = rde_pkg::RDE_RING_READY;
      end
      rde_pkg::RDE_RING_EMPTY: begin
        if (ringReadyAccess) state_nxt = rde_pkg::RDE_RING_READY;
      end
    endcase
    if (stopCmd) state_nxt = rde_pkg::RDE_RING_STOPPED;
    else if (ringDefine) state_nxt = rde_pkg::RDE_RING_STOPPED;
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_r <= rde_pkg::RDE_RING_STOPPED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Flags cleared only by redefinition or ring ready; a new fault wins
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      par_r <= 1'b0;
      opErr_r <= 1'b0;
    end else begin
      par_r <= (inFetch && fetchParityErr) || (par_r && !reArm);
      opErr_r <= (inFetch && operationErr) || (opErr_r && !reArm);
    end
  end
endmodule // rde_ring_ctl

// [core/rde_error_top.sv]
`timescale 1ns/1ps
// Error detection and recovery for a descriptor-ring frame DMA interface
// Notes on behaviour
// - Controller timeout on receive sets overrun, clears both receive enables, aborts receive.
// - Controller timeout on transmit sets underrun, aborts frame with error, clears enable.
// - Internal memory parity error on transmit sets flag, aborts frame, clears enable.
// - MAC handshake error sets flag, aborts receive, resynchronises on the next frame.
// - Internal memory overflow sets memory overrun flag; host must fix setup and reset.
// - Parity error toward system bus sets the port A or port B flag.
// - Port parity on transmit data stops loading, marks error frame, aborts if sending.
// - After transmit data parity, write error indication and keep processing the ring.
// - Transmit indication reports parity abort with parity flag and parity error code.
// - Port-aborted transfer sets indication error bit and a parity cause code.
// - Descriptor parity stops fetch; descriptor not loaded; read pointer unchanged.
// - Descriptor parity empties ring, sets parity, not-ready and ring-error status.
// - Host write with bad parity is ignored and sets host access parity flag.
// - Command extension written with bad parity discards the following command.
// - Parity error on destination ring access sets destination ring error flag.
// - Ring parity flag set on entry read error; cleared by redefine or ready.
// - Ring operation error flag set on port or marker error; same clearing.
// - Receive descriptor fetch starts only once the ring is defined and ready; the code needs only the ready state, even without a define.
// - Each receive indication written back is eight bytes long.
module rde_error_top (
  input wire logic mclk,
  input wire logic reset_n,
  // Event inputs from the data paths
  input wire logic rxCtrlTimeout,
  input wire logic txCtrlTimeout,
  input wire logic txMemParityErr,
  input wire logic macHandshakeErr,
  input wire logic rxFrameStart,
  input wire logic memOverflow,
  input wire logic portARxParityErr,
  input wire logic portBRxParityErr,
  input wire logic txPortParityErr,
  input wire logic txOnLine,
  input wire logic dmaPortErr,
  input wire logic dmaPortParityLate,
  input wire logic destRingParityErr,
  // Host access side
  input wire logic hostWrite,
  input wire logic hostWriteParityErr,
  input wire logic hostExtWrite,
  input wire logic hostCmdWrite,
  input wire logic [rde_pkg::IE_WIDTH-1:0] ieClear,
  input wire logic clrRingErr,
  input wire logic clrRingNotReady,
  input wire logic clrHostParity,
  input wire logic clrDestRing,
  input wire logic rxEnableSet,
  input wire logic txEnableSet,
  // Receive ring control
  input wire logic ringDefine,
  input wire logic ringReadyAccess,
  input wire logic stopCmd,
  input wire logic fetchStart,
  input wire logic fetchDone,
  input wire logic fetchParityErr,
  input wire logic operationErr,
  input wire logic indStart,
  // Outputs
  output logic [rde_pkg::IE_WIDTH-1:0] internalErrorStatus,
  output logic receiveEnableBitOne,
  output logic receiveEnableBitTwo,
  output logic transmitEnableBit,
  output logic receiveAbortSignal,
  output logic txFrameAbort,
  output logic txStopLoad,
  output logic txErrorFrame,
  output logic txIndWrite,
  output logic framePartityAbortFlag,
  output logic [2:0] txPortErrCode,
  output logic transferErrorBit,
  output logic [2:0] dmaPortErrCode,
  output logic ringNotReadyFlag,
  output logic ringErrorFlag,
  output logic hostAccessParityFlag,
  output logic destinationRingErrorFlag,
  output logic hostWriteAccept,
  output logic hostCmdAccept,
  output logic [1:0] ringState,
  output logic ringParityFlag,
  output logic ringOperationErrorFlag,
  output logic fetchAllowed,
  output logic loadDescriptor,
  output logic indByteValid,
  output logic [3:0] indByteIndex
);
  localparam int IW = rde_pkg::IE_WIDTH;

  // Reset release synchroniser
  logic rstMeta_r;
  logic rstN;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  // Internal error status events
  logic [IW-1:0] ieSet;
  always_comb begin
    ieSet = rde_pkg::IE_RESET;
    ieSet[rde_pkg::IE_OVERRUN] = rxCtrlTimeout;
    ieSet[rde_pkg::IE_UNDERRUN] = txCtrlTimeout;
    ieSet[rde_pkg::IE_TXPAR] = txMemParityErr;
    ieSet[rde_pkg::IE_MACHS] = macHandshakeErr;
    ieSet[rde_pkg::IE_MEMOVR] = memOverflow;
    ieSet[rde_pkg::IE_PORTA] = portARxParityErr;
    ieSet[rde_pkg::IE_PORTB] = portBRxParityErr;
  end

  // Sticky until the host clears; set wins a same-cycle clear
  rde_sticky_reg #(.WIDTH(IW)) uErrStat (
    .mclk(mclk),
    .rstN(rstN),
    .setVec(ieSet),
    .clrVec(ieClear),
    .flags(internalErrorStatus)
  );

  // Status register flags: ring not ready, ring error, host parity, dest ring
  wire hostParityEvt = hostWrite && hostWriteParityErr;
  wire ringErrEvt;
  logic [3:0] srSet;
  logic [3:0] srClr;
  logic [3:0] srFlags;
  assign srSet = {destRingParityErr, hostParityEvt, ringErrEvt, ringErrEvt};
  assign srClr = {clrDestRing, clrHostParity, clrRingErr, clrRingNotReady};
  rde_sticky_reg #(.WIDTH(4)) uSr (
    .mclk(mclk),
    .rstN(rstN),
    .setVec(srSet),
    .clrVec(srClr),
    .flags(srFlags)
  );
  assign ringNotReadyFlag = srFlags[0];
  assign ringErrorFlag = srFlags[1];
  assign hostAccessParityFlag = srFlags[2];
  assign destinationRingErrorFlag = srFlags[3];

  // Bad-parity host writes are dropped outright
  assign hostWriteAccept = hostWrite && !hostWriteParityErr;

  // A bad command extension poisons the next command write
  logic extBad_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      extBad_r <= 1'b0;
    end else if (hostExtWrite) begin
      extBad_r <= hostWriteParityErr;
    end else if (hostCmdWrite) begin
      extBad_r <= 1'b0;
    end
  end
  assign hostCmdAccept = hostCmdWrite && !hostWriteParityErr && !extBad_r;

  // Enable bits: host sets, errors clear; the error wins
  logic re1_r;
  logic re2_r;
  logic txEn_r;
  wire rxKill = rxCtrlTimeout;
  wire txKill = txCtrlTimeout || txMemParityErr;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      re1_r <= 1'b0;
      re2_r <= 1'b0;
      txEn_r <= 1'b0;
    end else begin
      re1_r <= !rxKill && (re1_r || rxEnableSet);
      re2_r <= !rxKill && (re2_r || rxEnableSet);
      txEn_r <= !txKill && (txEn_r || txEnableSet);
    end
  end
  assign receiveEnableBitOne = re1_r;
  assign receiveEnableBitTwo = re2_r;
  assign transmitEnableBit = txEn_r;

  // Receive abort pulse; handshake error resyncs at next frame start
  logic rxAbort_r;
  logic resync_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxAbort_r <= 1'b0;
      resync_r <= 1'b0;
    end else begin
      // While resynchronising the frame is already dropped, so a repeat handshake error gives no second abort; an rx timeout still aborts
      rxAbort_r <= rxCtrlTimeout || (macHandshakeErr && !resync_r);
      resync_r <= macHandshakeErr || (resync_r && !rxFrameStart);
    end
  end
  assign receiveAbortSignal = rxAbort_r;

  // Transmit frame error handling and indication
  logic txAbort_r;
  logic txStop_r;
  logic txInd_r;
  logic parAbort_r;
  logic [2:0] txCode_r;
  wire txPortAbort = txPortParityErr && txOnLine;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      txAbort_r <= 1'b0;
      txStop_r <= 1'b0;
      txInd_r <= 1'b0;
      parAbort_r <= 1'b0;
      txCode_r <= rde_pkg::PERR_NONE;
    end else begin
      txAbort_r <= txCtrlTimeout || txMemParityErr || txPortAbort;
      txStop_r <= txPortParityErr;
      txInd_r <= txPortParityErr || txCtrlTimeout;
      if (txPortParityErr) begin
        parAbort_r <= 1'b1;
        txCode_r <= txOnLine ? rde_pkg::PERR_PAR_LATE : rde_pkg::PERR_PAR_DATA;
      end else if (txCtrlTimeout) begin
        parAbort_r <= 1'b0;
        txCode_r <= rde_pkg::PERR_NONE;
      end
    end
  end
  assign txFrameAbort = txAbort_r;
  assign txStopLoad = txStop_r;
  assign txErrorFrame = txStop_r;
  assign txIndWrite = txInd_r;
  assign framePartityAbortFlag = parAbort_r;
  assign txPortErrCode = txCode_r;

  // DMA transfer indication error reporting
  logic xferErr_r;
  logic [2:0] dmaCode_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      xferErr_r <= 1'b0;
      dmaCode_r <= rde_pkg::PERR_NONE;
    end else if (dmaPortErr) begin
      xferErr_r <= 1'b1;
      dmaCode_r <= dmaPortParityLate ? rde_pkg::PERR_PAR_LATE : rde_pkg::PERR_PAR_DATA;
    end else if (indStart) begin
      xferErr_r <= 1'b0;
      dmaCode_r <= rde_pkg::PERR_NONE;
    end
  end
  assign transferErrorBit = xferErr_r;
  assign dmaPortErrCode = dmaCode_r;

  // Receive ring
  rde_pkg::rde_ring_state_t ringStateE;
  rde_ring_ctl uRing (
    .mclk(mclk),
    .rstN(rstN),
    .ringDefine(ringDefine),
    .ringReadyAccess(ringReadyAccess),
    .stopCmd(stopCmd),
    .fetchStart(fetchStart),
    .fetchDone(fetchDone),
    .fetchParityErr(fetchParityErr),
    .operationErr(operationErr),
    .ringState(ringStateE),
    .ringParityFlag(ringParityFlag),
    .ringOperationErrorFlag(ringOperationErrorFlag),
    .ringErrEvent(ringErrEvt),
    .fetchAllowed(fetchAllowed),
    .loadDescriptor(loadDescriptor)
  );
  assign ringState = ringStateE;

  // Indication writer: eight byte beats per receive indication
  logic indBusy_r;
  logic [3:0] indCnt_r;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      indBusy_r <= 1'b0;
      indCnt_r <= 4'h0;
    end else if (!indBusy_r) begin
      indBusy_r <= indStart;
      indCnt_r <= 4'h0;
    end else begin
      indBusy_r <= (indCnt_r != rde_pkg::IND_BYTES_M1);
      indCnt_r <= indCnt_r + 4'h1;
    end
  end
  assign indByteValid = indBusy_r;
  assign indByteIndex = indCnt_r;
endmodule // rde_error_top

// [test/rde_error_chk.sv]
// Assertion checker for the ring DMA error handling block
`timescale 1ns/1ps
module rde_error_chk (
  input wire logic mclk, reset_n,
  input wire logic rxCtrlTimeout, txCtrlTimeout, txMemParityErr, macHandshakeErr,
  input wire logic txPortParityErr, txOnLine, dmaPortErr, dmaPortParityLate,
  input wire logic hostWrite, hostWriteParityErr, hostExtWrite, hostCmdWrite, rxFrameStart,
  input wire logic ringDefine, ringReadyAccess, fetchParityErr, operationErr, indStart,
  input wire logic [6:0] ieClear, internalErrorStatus,
  input wire logic receiveEnableBitOne, receiveEnableBitTwo, transmitEnableBit,
  input wire logic receiveAbortSignal, txFrameAbort, txStopLoad, txErrorFrame, txIndWrite,
  input wire logic framePartityAbortFlag, transferErrorBit, ringNotReadyFlag, ringErrorFlag,
  input wire logic hostAccessParityFlag, hostWriteAccept, hostCmdAccept,
  input wire logic ringParityFlag, ringOperationErrorFlag, fetchAllowed, loadDescriptor,
  input wire logic indByteValid,
  input wire logic [2:0] txPortErrCode, dmaPortErrCode,
  input wire logic [1:0] ringState,
  input wire logic [3:0] indByteIndex
);
  // Ports are grouped per line to keep the checker compact
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Resync window after a handshake error, closed by the next frame start
  logic hsPend_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) hsPend_r <= 1'b0;
    else hsPend_r <= macHandshakeErr || (hsPend_r && !rxFrameStart);
  end

  a_overrun_rx_off: assert property (rxCtrlTimeout |=> internalErrorStatus[0] &&
    receiveAbortSignal && !receiveEnableBitOne && !receiveEnableBitTwo)
    else $error("overrun response wrong");
  a_underrun_tx_off: assert property (txCtrlTimeout |=> internalErrorStatus[1] &&
    txFrameAbort && !transmitEnableBit) else $error("underrun response wrong");
  a_txpar_tx_off: assert property (txMemParityErr |=> internalErrorStatus[2] &&
    txFrameAbort && !transmitEnableBit) else $error("tx parity response wrong");
  a_mac_hs_abort: assert property (macHandshakeErr && !hsPend_r |=>
    internalErrorStatus[3] && receiveAbortSignal) else $error("handshake response wrong");
  // A set bit may only drop where the host asked for it
  a_status_sticky: assert property (1 |=>
    ($past(internalErrorStatus) & ~$past(ieClear) & ~internalErrorStatus) == 7'h00)
    else $error("status bit lost");
  a_host_par_ignore: assert property (hostWrite && hostWriteParityErr |->
    !hostWriteAccept ##1 hostAccessParityFlag) else $error("bad host write taken");
  a_cmd_poisoned: assert property (hostExtWrite && hostWriteParityErr ##1
    hostCmdWrite && !hostExtWrite |-> !hostCmdAccept) else $error("command not dropped");
  a_desc_par_empty: assert property (ringState == 2'h3 && fetchParityErr |->
    !loadDescriptor ##1 ringState == 2'h2 && ringParityFlag && ringNotReadyFlag
    && ringErrorFlag) else $error("descriptor parity handling wrong");
  a_ring_flag_clear: assert property ((ringDefine || ringReadyAccess) &&
    !fetchParityErr && !operationErr |=> !ringParityFlag && !ringOperationErrorFlag)
    else $error("ring flags not cleared");
  // Fetch may only be entered from the ready state
  a_fetch_gate: assert property (ringState == 2'h3 && $past(ringState) != 2'h3 |->
    $past(ringState) == 2'h1 && $past(fetchAllowed))
    else $error("fetch outside ready");
  a_ind_eight: assert property (indStart && !indByteValid |=>
    indByteValid && indByteIndex == 4'h0 ##7 indByteValid && indByteIndex == 4'h7
    ##1 !indByteValid) else $error("indication length wrong");
  a_tx_port_par: assert property (txPortParityErr |=> txStopLoad && txErrorFrame &&
    framePartityAbortFlag && txPortErrCode == ($past(txOnLine) ? 3'h7 : 3'h2)
    && txFrameAbort == $past(txOnLine)) else $error("tx port parity wrong");
  a_tx_ind_write: assert property (txPortParityErr |-> ##[1:20] txIndWrite)
    else $error("no error indication written");
  a_dma_code: assert property (dmaPortErr |=> transferErrorBit &&
    dmaPortErrCode == ($past(dmaPortParityLate) ? 3'h7 : 3'h2)) else $error("dma code wrong");

  c_desc_par: cover property (ringState == 2'h3 && fetchParityErr);
  c_ind: cover property (indStart && !indByteValid);
  c_cmd_drop: cover property (hostCmdWrite && !hostCmdAccept);
endmodule // rde_error_chk

bind rde_error_top rde_error_chk i_rde_error_chk (.*);

// [test/rde_mac_model.sv]
// Behavioural model of the MAC on the far side of the frame interface
`timescale 1ns/1ps
module rde_mac_model (
  input wire logic mclk,
  input wire logic sendFrame,
  input wire logic receiveAbortSignal,
  input wire logic txFrameAbort,
  output logic txOnLine,
  output logic rxFrameStart
);
  logic [1:0] gap_r;
  initial begin
    txOnLine = 1'b0;
    rxFrameStart = 1'b0;
    gap_r = 2'h0;
  end
  // Frame stays on the line until the device aborts it; a receive abort
  // drops the frame and the next one starts after a short idle gap
  always @(posedge mclk) begin
    if (txFrameAbort) txOnLine <= 1'b0;
    else if (sendFrame) txOnLine <= 1'b1;
    rxFrameStart <= (gap_r == 2'h1);
    if (receiveAbortSignal) gap_r <= 2'h3;
    else if (gap_r != 2'h0) gap_r <= gap_r - 2'h1;
  end
endmodule // rde_mac_model

// [test/tb_rde_error_top.sv]
// Self-checking testbench for the ring DMA error handling block
`timescale 1ns/1ps
module tb_rde_error_top;
  logic mclk, reset_n, sendFrame, txOnLine, rxFrameStart;
  logic rxCtrlTimeout, txCtrlTimeout, txMemParityErr, macHandshakeErr, memOverflow;
  logic portARxParityErr, portBRxParityErr, txPortParityErr, dmaPortErr, dmaPortParityLate;
  logic destRingParityErr, hostWrite, hostWriteParityErr, hostExtWrite, hostCmdWrite;
  logic clrRingErr, clrRingNotReady, clrHostParity, clrDestRing;
  logic rxEnableSet, txEnableSet, ringDefine, ringReadyAccess, stopCmd, fetchStart;
  logic fetchDone, fetchParityErr, operationErr, indStart;
  logic [6:0] ieClear, internalErrorStatus;
  logic receiveEnableBitOne, receiveEnableBitTwo, transmitEnableBit, receiveAbortSignal;
  logic txFrameAbort, txStopLoad, txErrorFrame, txIndWrite, framePartityAbortFlag;
  logic transferErrorBit, ringNotReadyFlag, ringErrorFlag, hostAccessParityFlag;
  logic destinationRingErrorFlag, hostWriteAccept, hostCmdAccept, ringParityFlag;
  logic ringOperationErrorFlag, fetchAllowed, loadDescriptor, indByteValid;
  logic [2:0] txPortErrCode, dmaPortErrCode;
  logic [1:0] ringState;
  logic [3:0] indByteIndex;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Rows: event bits {portA,portB,mem,mac,txpar,tx,rx}, then {rxAbort,txAbort,rx1,rx2,tx}
  logic [11:0] rows [7] = '{12'h031, 12'h04e, 12'h08e, 12'h117, 12'h207, 12'h407, 12'h807};

  rde_error_top i_rde_error_top (.*);
  rde_mac_model i_rde_mac_model (.*);

  always #2.5 mclk = ~mclk;

  task chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", n, exp, got);
      err_total++;
    end
  endtask

  // All pulse inputs drop at the falling edge so each pulse lasts one cycle
  task tick;
    @(negedge mclk);
    {rxCtrlTimeout, txCtrlTimeout, txMemParityErr, macHandshakeErr, memOverflow,
     portARxParityErr, portBRxParityErr, txPortParityErr, dmaPortErr, dmaPortParityLate,
     destRingParityErr, hostWrite, hostWriteParityErr, hostExtWrite, hostCmdWrite,
     clrRingErr, clrRingNotReady, clrHostParity, clrDestRing,
     rxEnableSet, txEnableSet, ringDefine, ringReadyAccess, stopCmd, fetchStart,
     fetchDone, fetchParityErr, operationErr, indStart, sendFrame} = '0;
    ieClear = 7'h00;
  endtask

  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, well above the roughly 75 cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      results;
    end
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    tick;
    repeat (4) @(negedge mclk);
    chk("reset", 8'h00, {1'b0, internalErrorStatus});
    reset_n = 1'b1;
    repeat (3) tick;
    // Each error event: flag, aborts and enables, then stickiness and host clear
    for (int i = 0; i < 7; i++) begin
      rxEnableSet = 1'b1;
      txEnableSet = 1'b1;
      tick;
      {portARxParityErr, portBRxParityErr, memOverflow, macHandshakeErr, txMemParityErr,
       txCtrlTimeout, rxCtrlTimeout} = rows[i][11:5];
      tick;
      chk("status", {1'b0, rows[i][11:5]}, {1'b0, internalErrorStatus});
      chk("abort_en", {3'h0, rows[i][4:0]}, {3'h0, receiveAbortSignal, txFrameAbort,
          receiveEnableBitOne, receiveEnableBitTwo, transmitEnableBit});
      tick;
      tick;
      chk("sticky", {1'b0, rows[i][11:5]}, {1'b0, internalErrorStatus});
      ieClear = 7'h7f;
      tick;
      chk("cleared", 8'h00, {1'b0, internalErrorStatus});
    end
    $display("test error_events done");
    // Host write with bad parity, then a poisoned command
    hostWrite = 1'b1;
    hostWriteParityErr = 1'b1;
    #1 chk("wr_refused", 8'h00, {7'h0, hostWriteAccept});
    tick;
    chk("host_par_flag", 8'h01, {7'h0, hostAccessParityFlag});
    hostExtWrite = 1'b1;
    hostWriteParityErr = 1'b1;
    clrHostParity = 1'b1;
    tick;
    hostCmdWrite = 1'b1;
    #1 chk("cmd_dropped", 8'h00, {7'h0, hostCmdAccept});
    chk("host_par_clr", 8'h00, {7'h0, hostAccessParityFlag});
    tick;
    hostCmdWrite = 1'b1;
    #1 chk("cmd_taken", 8'h01, {7'h0, hostCmdAccept});
    tick;
    $display("test host_access done");
    // Descriptor parity fault and host recovery by clear and ring ready
    chk("ring_idle", 8'h00, {5'h0, ringState, fetchAllowed});
    ringReadyAccess = 1'b1;
    tick;
    chk("ring_ready", 8'h03, {5'h0, ringState, fetchAllowed});
    fetchStart = 1'b1;
    tick;
    fetchParityErr = 1'b1;
    fetchDone = 1'b1;
    #1 chk("no_load", 8'h00, {7'h0, loadDescriptor});
    tick;
    chk("ring_fault", 8'h2e, {2'h0, ringState, ringParityFlag, ringNotReadyFlag,
        ringErrorFlag, fetchAllowed});
    clrRingErr = 1'b1;
    clrRingNotReady = 1'b1;
    tick;
    chk("host_clear", 8'h04, {5'h0, ringParityFlag, ringNotReadyFlag, ringErrorFlag});
    ringReadyAccess = 1'b1;
    tick;
    chk("reready", 8'h02, {5'h0, ringState, ringParityFlag});
    fetchStart = 1'b1;
    tick;
    fetchDone = 1'b1;
    #1 chk("load", 8'h01, {7'h0, loadDescriptor});
    tick;
    fetchStart = 1'b1;
    tick;
    operationErr = 1'b1;
    tick;
    chk("oper_flag", 8'h01, {7'h0, ringOperationErrorFlag});
    stopCmd = 1'b1;
    tick;
    chk("stopped", 8'h00, {6'h0, ringState});
    ringDefine = 1'b1;
    tick;
    chk("redefined", 8'h00, {6'h0, ringOperationErrorFlag, ringParityFlag});
    $display("test ring_recovery done");
    // Port parity on transmit data, on the line and before it
    sendFrame = 1'b1;
    tick;
    txPortParityErr = 1'b1;
    tick;
    chk("tx_par_line", 8'hf7, {txStopLoad, txErrorFrame, txFrameAbort,
        framePartityAbortFlag, 1'b0, txPortErrCode});
    tick;
    tick;
    txPortParityErr = 1'b1;
    tick;
    chk("tx_par_load", 8'hd2, {txStopLoad, txErrorFrame, txFrameAbort,
        framePartityAbortFlag, 1'b0, txPortErrCode});
    dmaPortErr = 1'b1;
    tick;
    chk("dma_data", 8'h0a, {4'h0, transferErrorBit, dmaPortErrCode});
    dmaPortErr = 1'b1;
    dmaPortParityLate = 1'b1;
    destRingParityErr = 1'b1;
    tick;
    chk("dma_late", 8'h0f, {4'h0, transferErrorBit, dmaPortErrCode});
    chk("dest_ring", 8'h01, {7'h0, destinationRingErrorFlag});
    clrDestRing = 1'b1;
    tick;
    chk("dest_clear", 8'h00, {7'h0, destinationRingErrorFlag});
    $display("test port_parity done");
    // Indication write-back: eight beats in order
    indStart = 1'b1;
    tick;
    for (int b = 0; b < 8; b++) begin
      chk("ind_beat", {4'h1, b[3:0]}, {3'h0, indByteValid, indByteIndex});
      tick;
    end
    chk("ind_end", 8'h00, {7'h0, indByteValid});
    $display("test indication done");
    results;
  end
endmodule // tb_rde_error_top
